//--- hw/dspc_ctrl.sv
/*
 dual serial port control top: apb register file, baud tick generation,
 pin routing for both ports, two transmit and two receive engines, interrupt.
 assumes an apb3 master on pclk; pads resolve each pin from out and oe.
*/
// Design decision made here: the APB slave port.
`include "dspc_regs.svh"
module dspc_ctrl (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq,
	input  wire logic [5:0]  p2_pin_in,
	output logic [5:0]       p2_pin_out,
	output logic [5:0]       p2_pin_oe,
	input  wire logic [3:0]  p1_pin_in,
	output logic [3:0]       p1_pin_out,
	output logic [3:0]       p1_pin_oe
);
	// registers
	logic [7:0]  p2ctl_q;
	logic [7:0]  p2rxbuf_q;
	logic [7:0]  pinsel_q;
	logic [7:0]  p1rxbuf_q;
	logic [7:0]  p2div_q;
	logic [7:0]  p1ctl_q;
	logic        t2sel_q;
	logic [7:0]  t1rld_q;
	logic [7:0]  t2rlh_q;
	logic [7:0]  t2rll_q;
	logic [3:0]  irqst_q;
	logic [3:0]  irqmsk_q;
	// bus
	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;
	logic        irq_q;
	logic [7:0]  idx;
	logic        hit;
	logic        setup;
	logic        wr_en;
	logic [7:0]  rd_d;
	// pins
	logic [5:0]  p2_s1_q;
	logic [5:0]  p2_s2_q;
	logic [3:0]  p1_s1_q;
	logic [3:0]  p1_s2_q;
	logic [5:0]  p2_out_q;
	logic [5:0]  p2_oe_q;
	logic [3:0]  p1_out_q;
	logic [3:0]  p1_oe_q;
	logic [5:0]  p2_out_d;
	logic [5:0]  p2_oe_d;
	logic [3:0]  p1_out_d;
	logic [3:0]  p1_oe_d;
	logic        p2_rx_line;
	logic        p1_rx_line;
	dspc_pkg::dspc_route_s p2_rt;
	dspc_pkg::dspc_route_s p1_rt;
	// engines
	dspc_pkg::dspc_mode_e  p1_mode;
	dspc_pkg::dspc_word_s  p2_word;
	dspc_pkg::dspc_word_s  p1_word;
	logic        p2_tx_line;
	logic        p2_tx_busy;
	logic        p2_tx_done;
	logic        p2_rx_done;
	logic        p1_tx_line;
	logic        p1_tx_busy;
	logic        p1_tx_done;
	logic        p1_rx_done;
	logic        p1_sclk;
	logic        p1_sync;
	logic [3:0]  irq_ev;
	// baud
	logic [1:0][17:0] per;
	wire  [1:0]  tick;
	logic [8:0]  t1_span;
	logic [16:0] t2_span;

	// port2 pin map: p0.0, p0.1, p3.5, p3.6, p0.2, p0.3 as 0..5
	function automatic dspc_pkg::dspc_route_s p2_route(input logic [3:0] code);
		dspc_pkg::dspc_route_s r;
		case (code)
		4'h0:    r = {3'h0, 3'h1, 2'h1};
		4'h1:    r = {3'h2, 3'h3, 2'h1};
		4'h2:    r = {3'h1, 3'h0, 2'h1};
		4'h3:    r = {3'h3, 3'h2, 2'h1};
		4'h4:    r = {3'h1, 3'h1, 2'h3};
		4'h5:    r = {3'h3, 3'h3, 2'h3};
		4'h6:    r = {3'h0, 3'h0, 2'h3};
		4'h7:    r = {3'h2, 3'h2, 2'h3};
		4'h8:    r = {3'h4, 3'h5, 2'h1};
		4'ha:    r = {3'h5, 3'h4, 2'h1};
		4'hc:    r = {3'h5, 3'h5, 2'h3};
		4'he:    r = {3'h4, 3'h4, 2'h3};
		default: r = {3'h0, 3'h0, 2'h0}; // undefined codes leave the port unconnected
		endcase
		return r;
	endfunction

	// port1 pin map: p3.0..p3.3 as 0..3
	function automatic dspc_pkg::dspc_route_s p1_route(input logic [2:0] code);
		dspc_pkg::dspc_route_s r;
		case (code)
		3'h0:    r = {3'h0, 3'h1, 2'h1};
		3'h1:    r = {3'h2, 3'h3, 2'h1};
		3'h2:    r = {3'h1, 3'h0, 2'h1};
		3'h3:    r = {3'h3, 3'h2, 2'h1};
		3'h4:    r = {3'h1, 3'h1, 2'h3};
		3'h5:    r = {3'h3, 3'h3, 2'h3};
		3'h6:    r = {3'h0, 3'h0, 2'h3};
		3'h7:    r = {3'h2, 3'h2, 2'h3};
		default: r = {3'h0, 3'h0, 2'h0};
		endcase
		return r;
	endfunction

	function automatic logic mapped(input logic [7:0] i);
		case (i)
		`DSPC_IDX_P2CTL, `DSPC_IDX_P2BUF, `DSPC_IDX_PINSEL, `DSPC_IDX_P1BUF,
		`DSPC_IDX_P2BAUD, `DSPC_IDX_P1CTL, `DSPC_IDX_P1CFG, `DSPC_IDX_T1RLD,
		`DSPC_IDX_T2RLH, `DSPC_IDX_T2RLL, `DSPC_IDX_IRQST, `DSPC_IDX_IRQMSK:
			mapped = 1'b1;
		default:
			mapped = 1'b0;
		endcase
	endfunction

	// address decode; misaligned or out of map answers with an error
	assign idx   = paddr[9:2];
	assign hit   = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0) && mapped(idx);
	assign setup = psel && !penable;
	assign wr_en = psel && penable && pready_q && pwrite && hit;

	assign p1_mode = dspc_pkg::dspc_mode_e'(p1ctl_q[7:6]);
	assign p1_sync = (p1_mode == dspc_pkg::P1_SHIFT);
	assign p2_rt   = p2_route(pinsel_q[7:4]);
	assign p1_rt   = p1_route(pinsel_q[2:0]);

	// read mux; buffers return the receive path only
	always_comb
	begin
		case (idx)
		`DSPC_IDX_P2CTL:  rd_d = p2ctl_q;
		`DSPC_IDX_P2BUF:  rd_d = p2rxbuf_q;
		`DSPC_IDX_PINSEL: rd_d = pinsel_q;
		`DSPC_IDX_P1BUF:  rd_d = p1rxbuf_q;
		`DSPC_IDX_P2BAUD: rd_d = p2div_q;
		`DSPC_IDX_P1CTL:  rd_d = p1ctl_q;
		`DSPC_IDX_P1CFG:  rd_d = {7'h0, t2sel_q};
		`DSPC_IDX_T1RLD:  rd_d = t1rld_q;
		`DSPC_IDX_T2RLH:  rd_d = t2rlh_q;
		`DSPC_IDX_T2RLL:  rd_d = t2rll_q;
		`DSPC_IDX_IRQST:  rd_d = {4'h0, irqst_q};
		`DSPC_IDX_IRQMSK: rd_d = {4'h0, irqmsk_q};
		default:          rd_d = 8'h00;
		endcase
	end

	// apb answer: no wait state, data captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end
		else
		begin
			pready_q  <= setup;
			pslverr_q <= setup && !hit;
			prdata_q  <= (setup && !pwrite && hit) ? {24'h00_0000, rd_d} : 32'h0000_0000;
		end

	// plain software registers
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			pinsel_q <= `DSPC_PINSEL_RST;
			p2div_q  <= 8'h00;
			t2sel_q  <= 1'b0;
			t1rld_q  <= 8'h00;
			t2rlh_q  <= 8'h00;
			t2rll_q  <= 8'h00;
			irqmsk_q <= 4'h0;
		end
		else if (wr_en)
		begin
			case (idx)
			`DSPC_IDX_PINSEL: pinsel_q <= pwdata[7:0] & `DSPC_PINSEL_WMASK;
			`DSPC_IDX_P2BAUD: p2div_q  <= pwdata[7:0];
			`DSPC_IDX_P1CFG:  t2sel_q  <= pwdata[0];
			`DSPC_IDX_T1RLD:  t1rld_q  <= pwdata[7:0];
			`DSPC_IDX_T2RLH:  t2rlh_q  <= pwdata[7:0];
			`DSPC_IDX_T2RLL:  t2rll_q  <= pwdata[7:0];
			`DSPC_IDX_IRQMSK: irqmsk_q <= pwdata[3:0];
			default:          t2sel_q  <= t2sel_q;
			endcase
		end

	// port2 control: hardware sets come last so they beat a clear
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			p2ctl_q <= 8'h00;
		else
		begin
			if (wr_en && idx == `DSPC_IDX_P2CTL)
				p2ctl_q <= pwdata[7:0] & `DSPC_P2CTL_WMASK;
			if (p2_tx_done)
				p2ctl_q[`DSPC_B_TI] <= 1'b1;
			if (p2_rx_done)
			begin
				p2ctl_q[`DSPC_B_RI]  <= 1'b1;
				p2ctl_q[`DSPC_B_RB8] <= p2_word.bit8;
			end
		end

	// port1 control, same flag behaviour
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			p1ctl_q <= 8'h00;
		else
		begin
			if (wr_en && idx == `DSPC_IDX_P1CTL)
				p1ctl_q <= pwdata[7:0];
			if (p1_tx_done)
				p1ctl_q[`DSPC_B_TI] <= 1'b1;
			if (p1_rx_done)
			begin
				p1ctl_q[`DSPC_B_RI]  <= 1'b1;
				p1ctl_q[`DSPC_B_RB8] <= p1_word.bit8;
			end
		end

	// receive buffers, only hardware loads them
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			p2rxbuf_q <= 8'h00;
			p1rxbuf_q <= 8'h00;
		end
		else
		begin
			if (p2_rx_done)
				p2rxbuf_q <= p2_word.data;
			if (p1_rx_done)
				p1rxbuf_q <= p1_word.data;
		end

	// interrupt status: write one to clear, a new event wins
	assign irq_ev = {p2_rx_done, p2_tx_done, p1_rx_done, p1_tx_done};
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			irqst_q <= 4'h0;
			irq_q   <= 1'b0;
		end
		else
		begin
			irqst_q <= (irqst_q & ~((wr_en && idx == `DSPC_IDX_IRQST) ? pwdata[3:0] : 4'h0)) | irq_ev;
			irq_q   <= |(irqst_q & irqmsk_q);
		end

	// tick periods in pclk cycles, sixteen ticks per bit, two per bit in port1 shift mode
	assign t1_span = `DSPC_FULL8 - {1'b0, t1rld_q};
	assign t2_span = `DSPC_FULL16 - {1'b0, t2rlh_q, t2rll_q};
	always_comb
	begin
		per[1] = {9'h000, p2div_q, 1'b0};
		case (p1_mode)
		dspc_pkg::P1_SHIFT:
			per[0] = 18'h0_0001;
		dspc_pkg::P1_FIX9:
			per[0] = p1ctl_q[`DSPC_B_BAUD_DOUBLE_BIT] ? 18'h0_0002 : 18'h0_0004;
		default:
			if (t2sel_q)
				per[0] = {t2_span, 1'b0};
			else if (p1ctl_q[`DSPC_B_BAUD_DOUBLE_BIT])
				per[0] = {8'h00, t1_span, 1'b0};
			else
				per[0] = {7'h00, t1_span, 2'h0};
		endcase
	end

	// tick counters; a zero period stops the port
	for (genvar g = 0; g < 2; g++)
	begin : g_baud
		logic [17:0] cnt_q;
		logic        tick_q;
		assign tick[g] = tick_q;
		always_ff @(posedge pclk or negedge presetn)
			if (!presetn)
			begin
				cnt_q  <= 18'h0_0000;
				tick_q <= 1'b0;
			end
			else if (per[g] == 18'h0_0000)
			begin
				cnt_q  <= 18'h0_0000;
				tick_q <= 1'b0;
			end
			else if (cnt_q >= per[g] - 18'h0_0001)
			begin
				cnt_q  <= 18'h0_0000;
				tick_q <= 1'b1;
			end
			else
			begin
				cnt_q  <= cnt_q + 18'h0_0001;
				tick_q <= 1'b0;
			end
	end

	// pin synchronisers
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			p2_s1_q <= '1;
			p2_s2_q <= '1;
			p1_s1_q <= '1;
			p1_s2_q <= '1;
		end
		else
		begin
			p2_s1_q <= p2_pin_in;
			p2_s2_q <= p2_s1_q;
			p1_s1_q <= p1_pin_in;
			p1_s2_q <= p1_s1_q;
		end

	// receive source; one-wire hides our own transmission
	always_comb
	begin
		p2_rx_line = 1'b1;
		p1_rx_line = 1'b1;
		if (p2_rt.on && !(p2_rt.one_wire && p2_tx_busy))
			p2_rx_line = p2_s2_q[p2_rt.rx];
		if (p1_rt.on && !(p1_rt.one_wire && p1_tx_busy))
			p1_rx_line = p1_s2_q[p1_rt.rx[1:0]];
	end

	// drive side; one-wire releases the pin when idle
	always_comb
	begin
		p2_out_d = '1;
		p2_oe_d  = '0;
		p1_out_d = '1;
		p1_oe_d  = '0;
		if (p2_rt.on && (!p2_rt.one_wire || p2_tx_busy))
		begin
			p2_out_d[p2_rt.tx] = p2_tx_line;
			p2_oe_d[p2_rt.tx]  = 1'b1;
		end
		if (p1_rt.on && p1_sync && !p1_rt.one_wire)
		begin
			// shift mode: data on the receive pin, clock on the transmit pin
			p1_out_d[p1_rt.rx[1:0]] = p1_tx_line;
			p1_oe_d[p1_rt.rx[1:0]]  = p1_tx_busy;
			p1_out_d[p1_rt.tx[1:0]] = p1_sclk;
			p1_oe_d[p1_rt.tx[1:0]]  = 1'b1;
		end
		else if (p1_rt.on && !p1_sync && (!p1_rt.one_wire || p1_tx_busy))
		begin
			p1_out_d[p1_rt.tx[1:0]] = p1_tx_line;
			p1_oe_d[p1_rt.tx[1:0]]  = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			p2_out_q <= '1;
			p2_oe_q  <= '0;
			p1_out_q <= '1;
			p1_oe_q  <= '0;
		end
		else
		begin
			p2_out_q <= p2_out_d;
			p2_oe_q  <= p2_oe_d;
			p1_out_q <= p1_out_d;
			p1_oe_q  <= p1_oe_d;
		end

	// port2 engines; frame select chooses the ninth bit
	dspc_tx u_p2_tx (
		.pclk     (pclk),
		.presetn  (presetn),
		.tick     (tick[1]),
		.start    (wr_en && idx == `DSPC_IDX_P2BUF),
		.data     (pwdata[7:0]),
		.ninth_en (p2ctl_q[`DSPC_B_FRAME]),
		.ninth    (p2ctl_q[`DSPC_B_TB8]),
		.sync     (1'b0),
		.line     (p2_tx_line),
		.sclk     (),
		.busy     (p2_tx_busy),
		.done     (p2_tx_done)
	);
	dspc_rx u_p2_rx (
		.pclk     (pclk),
		.presetn  (presetn),
		.tick     (tick[1]),
		.en       (p2ctl_q[`DSPC_B_REN]),
		.line     (p2_rx_line),
		.ninth_en (p2ctl_q[`DSPC_B_FRAME]),
		.done     (p2_rx_done),
		.word     (p2_word)
	);

	// port1 engines; shift mode receive is not offered
	dspc_tx u_p1_tx (
		.pclk     (pclk),
		.presetn  (presetn),
		.tick     (tick[0]),
		.start    (wr_en && idx == `DSPC_IDX_P1BUF),
		.data     (pwdata[7:0]),
		.ninth_en (p1ctl_q[7]),
		.ninth    (p1ctl_q[`DSPC_B_TB8]),
		.sync     (p1_sync),
		.line     (p1_tx_line),
		.sclk     (p1_sclk),
		.busy     (p1_tx_busy),
		.done     (p1_tx_done)
	);
	dspc_rx u_p1_rx (
		.pclk     (pclk),
		.presetn  (presetn),
		.tick     (tick[0]),
		.en       (p1ctl_q[`DSPC_B_REN] && !p1_sync),
		.line     (p1_rx_line),
		.ninth_en (p1ctl_q[7]),
		.done     (p1_rx_done),
		.word     (p1_word)
	);

	assign prdata     = prdata_q;
	assign pready     = pready_q;
	assign pslverr    = pslverr_q;
	assign irq        = irq_q;
	assign p2_pin_out = p2_out_q;
	assign p2_pin_oe  = p2_oe_q;
	assign p1_pin_out = p1_out_q;
	assign p1_pin_oe  = p1_oe_q;
endmodule

//--- hw/dspc_regs.svh
/*
 register map, field positions, reset values and timing counts of the
 dual serial port control block.
 assumes inclusion by bare name from every design file that decodes registers.
*/
`ifndef DSPC_REGS_SVH
`define DSPC_REGS_SVH

// register indexes; byte address is four times the index
`define DSPC_IDX_P2CTL  8'h8e
`define DSPC_IDX_P2BUF  8'h8f
`define DSPC_IDX_PINSEL 8'h93
`define DSPC_IDX_P1BUF  8'h99
`define DSPC_IDX_P2BAUD 8'h9f
`define DSPC_IDX_P1CTL  8'ha0
`define DSPC_IDX_P1CFG  8'ha1
`define DSPC_IDX_T1RLD  8'ha2
`define DSPC_IDX_T2RLH  8'ha3
`define DSPC_IDX_T2RLL  8'ha4
`define DSPC_IDX_IRQST  8'ha5
`define DSPC_IDX_IRQMSK 8'ha6

// control fields, same layout for both ports except baud double, which only port1 has
`define DSPC_B_FRAME 7
`define DSPC_B_BAUD_DOUBLE_BIT  5
`define DSPC_B_REN   4
`define DSPC_B_TB8   3
`define DSPC_B_RB8   2
`define DSPC_B_TI    1
`define DSPC_B_RI    0
`define DSPC_P2CTL_WMASK  8'h9f
`define DSPC_PINSEL_WMASK 8'hf7
`define DSPC_PINSEL_RST   8'h11

// interrupt status bits
`define DSPC_IRQ_P1TX 0
`define DSPC_IRQ_P1RX 1
`define DSPC_IRQ_P2TX 2
`define DSPC_IRQ_P2RX 3

// timing: sixteen ticks per bit, sampled at the middle tick
`define DSPC_OVS_LAST 4'hf
`define DSPC_OVS_MID  4'h7
`define DSPC_FULL16   17'h1_0000
`define DSPC_FULL8    9'h100
`endif

//--- hw/dspc_pkg.sv
/*
 types shared by the dual serial port control modules.
 assumes nothing beyond a SystemVerilog compiler.
*/
package dspc_pkg;
	typedef enum logic [1:0] {P1_SHIFT, P1_VAR8, P1_FIX9, P1_VAR9} dspc_mode_e;
	typedef enum logic {TX_IDLE, TX_RUN} dspc_tx_e;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} dspc_rx_e;
	// pin route: receive index, transmit index, one-wire, connected
	typedef struct packed {
		logic [2:0] rx;
		logic [2:0] tx;
		logic       one_wire;
		logic       on;
	} dspc_route_s;
	typedef struct packed {
		logic [7:0] data;
		logic       bit8;
	} dspc_word_s;
endpackage

//--- hw/dspc_tx.sv
/*
 serial transmit engine: start, eight data, optional ninth, stop,
 or eight bits with a shift clock in synchronous mode.
 assumes one tick pulse per sixteenth of a bit, or per half bit when sync.
*/
`include "dspc_regs.svh"
module dspc_tx (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       tick,
	input  wire logic       start,
	input  wire logic [7:0] data,
	input  wire logic       ninth_en,
	input  wire logic       ninth,
	input  wire logic       sync,
	output logic            line,
	output logic            sclk,
	output logic            busy,
	output logic            done
);
	dspc_pkg::dspc_tx_e st_q;
	logic [10:0]        sh_q;
	logic [3:0]         bit_q;
	logic [3:0]         cnt_q;
	logic               sync_q;
	logic [3:0]         last_q;
	logic               bit_end;

	assign bit_end = (st_q == dspc_pkg::TX_RUN) && tick && (cnt_q == (sync_q ? 4'h1 : `DSPC_OVS_LAST));
	assign line    = sh_q[0];
	assign busy    = (st_q == dspc_pkg::TX_RUN);
	// shift clock idles high, low in first half of each bit
	assign sclk    = ~(busy && sync_q && !cnt_q[0]);

	// frame sequencer; a start while busy is ignored
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			st_q   <= dspc_pkg::TX_IDLE;
			sh_q   <= '1;
			bit_q  <= 4'h0;
			cnt_q  <= 4'h0;
			sync_q <= 1'b0;
			last_q <= 4'h0;
		end
		else
		begin
			case (st_q)
			dspc_pkg::TX_IDLE:
				if (start)
				begin
					st_q   <= dspc_pkg::TX_RUN;
					sync_q <= sync;
					bit_q  <= 4'h0;
					cnt_q  <= 4'h0;
					if (sync)
					begin
						sh_q   <= {3'h7, data};
						last_q <= 4'h7;
					end
					else
					begin
						sh_q   <= {1'b1, ninth_en ? ninth : 1'b1, data, 1'b0};
						last_q <= ninth_en ? 4'ha : 4'h9;
					end
				end
			dspc_pkg::TX_RUN:
				if (tick)
				begin
					cnt_q <= bit_end ? 4'h0 : cnt_q + 4'h1;
					if (bit_end && bit_q == last_q)
						st_q <= dspc_pkg::TX_IDLE;
					else if (bit_end)
					begin
						sh_q  <= {1'b1, sh_q[10:1]};
						bit_q <= bit_q + 4'h1;
					end
				end
			default:
				st_q <= dspc_pkg::TX_IDLE;
			endcase
		end

	// done at start of stop bit, or after eighth bit when sync
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			done <= 1'b0;
		else
			done <= bit_end && (sync_q ? bit_q == last_q : bit_q == last_q - 4'h1);
endmodule

//--- hw/dspc_rx.sv
/*
 serial receive engine: start detect, mid-bit sampling, 8 or 9 data bits
 and stop bit; bit8 returns the ninth bit or, for 8-bit frames, the stop bit.
 assumes a line already passed through a synchroniser and 16 ticks per bit.
*/
`include "dspc_regs.svh"
module dspc_rx (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         tick,
	input  wire logic         en,
	input  wire logic         line,
	input  wire logic         ninth_en,
	output logic              done,
	output dspc_pkg::dspc_word_s word
);
	dspc_pkg::dspc_rx_e st_q;
	logic [9:0]         sh_q;
	logic [9:0]         nsh;
	logic [3:0]         bit_q;
	logic [3:0]         cnt_q;
	logic               prev_q;
	logic               last;

	assign nsh  = {line, sh_q[9:1]};
	assign last = (bit_q == (ninth_en ? 4'h9 : 4'h8));

	// receive sequencer; dropping enable abandons the frame
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			st_q   <= dspc_pkg::RX_IDLE;
			sh_q   <= '0;
			bit_q  <= 4'h0;
			cnt_q  <= 4'h0;
			prev_q <= 1'b1;
			done   <= 1'b0;
			word   <= '0;
		end
		else
		begin
			prev_q <= line;
			done   <= 1'b0;
			case (st_q)
			dspc_pkg::RX_IDLE:
				if (en && prev_q && !line)
				begin
					st_q  <= dspc_pkg::RX_START;
					cnt_q <= 4'h0;
				end
			dspc_pkg::RX_START:
				if (!en)
					st_q <= dspc_pkg::RX_IDLE;
				else if (tick && cnt_q == `DSPC_OVS_MID)
				begin
					// a glitch shorter than half a bit is not a start
					st_q  <= line ? dspc_pkg::RX_IDLE : dspc_pkg::RX_BITS;
					cnt_q <= 4'h0;
					bit_q <= 4'h0;
				end
				else if (tick)
					cnt_q <= cnt_q + 4'h1;
			dspc_pkg::RX_BITS:
				if (!en)
					st_q <= dspc_pkg::RX_IDLE;
				else if (tick && cnt_q == `DSPC_OVS_LAST)
				begin
					cnt_q <= 4'h0;
					sh_q  <= nsh;
					bit_q <= bit_q + 4'h1;
					if (last)
					begin
						st_q      <= dspc_pkg::RX_IDLE;
						done      <= 1'b1;
						word.data <= ninth_en ? nsh[7:0] : nsh[8:1];
						word.bit8 <= ninth_en ? nsh[8] : nsh[9];
					end
				end
				else if (tick)
					cnt_q <= cnt_q + 4'h1;
			default:
				st_q <= dspc_pkg::RX_IDLE;
			endcase
		end
endmodule

//--- sim/dspc_ctrl_monitor.sv
/*
 checker on the apb side and the port2 transmit pin of the serial top.
 assumes binding to dspc_ctrl; watches ports only.
*/
`include "dspc_regs.svh"
module dspc_ctrl_monitor (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic [11:0] paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [5:0]  p2_pin_out,
	input wire logic [5:0]  p2_pin_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// one wait-free access cycle after each setup
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	a_ready_single: assert property (pready |=> !pready)
		else $error("pready held too long");
	a_ready_cause: assert property (pready |-> $past(psel && !penable))
		else $error("pready without setup");
	// read data is zero outside the answer and above the byte
	a_idle_rdata: assert property (!pready |-> prdata == 32'h0000_0000)
		else $error("prdata not zero while idle");
	a_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h00_0000)
		else $error("prdata upper bits set");
	a_err_answer: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
		else $error("pslverr outside answer");
	a_misaligned_err: assert property (psel && penable && pready && paddr[1:0] != 2'b00 |-> pslverr)
		else $error("misaligned access not refused");
	a_buffer_mapped: assert property (psel && penable && pready && paddr == {2'b00, `DSPC_IDX_P2BUF, 2'b00}
		|-> !pslverr)
		else $error("data buffer refused");
	// a bit lasts at least 31 clocks for any divisor (the start bit can lose one tick phase), so a start bit cannot be short
	a_start_width: assert property ($fell(p2_pin_out[3]) && p2_pin_oe[3] |=> (!p2_pin_out[3]) [*8])
		else $error("start bit too short");
endmodule
bind dspc_ctrl dspc_ctrl_monitor dspc_ctrl_monitor_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
	.psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.p2_pin_out(p2_pin_out), .p2_pin_oe(p2_pin_oe));

//--- sim/dspc_remote.sv
/*
 remote serial device on the port2 lines: receives and sends frames.
 assumes the bench resolves pins; idle level is the pull-up level.
*/
module dspc_remote (
	input wire logic        pclk,
	input wire logic        line_in,
	input wire logic [15:0] bit_cycles,
	input wire logic        nine,
	input wire logic        send,
	input wire logic [8:0]  send_word,
	output logic            line_out,
	output logic            got,
	output logic [8:0]      got_word
);
	timeunit 1ns;
	timeprecision 1ps;
	// receive: start edge, then sample every bit at its middle
	initial
	begin
		got = 1'b0;
		got_word = 9'h000;
		forever
		begin
			@(posedge pclk);
			if (line_in === 1'b0)
			begin
				repeat (bit_cycles / 2) @(posedge pclk);
				for (int i = 0; i < (nine ? 9 : 8); i++)
				begin
					repeat (bit_cycles) @(posedge pclk);
					got_word[i] = line_in;
				end
				if (!nine)
					got_word[8] = 1'b0;
				repeat (bit_cycles) @(posedge pclk);
				got <= 1'b1;
				@(posedge pclk);
				got <= 1'b0;
			end
		end
	end
	// transmit: start, data lsb first, optional ninth, stop
	initial
	begin
		line_out = 1'b1;
		forever
		begin
			@(posedge pclk);
			if (send === 1'b1)
			begin
				line_out <= 1'b0;
				repeat (bit_cycles) @(posedge pclk);
				for (int i = 0; i < (nine ? 9 : 8); i++)
				begin
					line_out <= send_word[i];
					repeat (bit_cycles) @(posedge pclk);
				end
				line_out <= 1'b1;
				repeat (bit_cycles) @(posedge pclk);
			end
		end
	end
endmodule

//--- sim/dspc_ctrl_bench.sv
/*
 self-checking bench for the serial control top with a remote device on port2.
 assumes port1 pins rest high; divisor never programmed to zero.
*/
`include "dspc_regs.svh"
module dspc_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic [5:0]  p2_in;
	logic [5:0]  p2_out;
	logic [5:0]  p2_oe;
	logic [3:0]  p1_in = 4'hf;
	logic [3:0]  p1_oe;
	logic [2:0]  rx_idx = 3'h2;
	logic [2:0]  tx_idx = 3'h3;
	logic [15:0] bitc = 16'h0020;
	logic        nine = 1'b0;
	logic        send = 1'b0;
	logic [8:0]  send_word = 9'h000;
	logic        r_line;
	logic        got;
	logic [8:0]  got_word;
	logic [32:0] reg_notes[$];
	logic [8:0]  ser_notes[$];
	int          mismatches = 0;
	int          num_checks = 0;
	integer      seed = 29829;
	logic [7:0]  d;
	// select code, receive pin, transmit pin of every defined port2 code
	logic [9:0]  routes [12] = '{{4'h0, 3'h0, 3'h1}, {4'h1, 3'h2, 3'h3}, {4'h2, 3'h1, 3'h0},
		{4'h3, 3'h3, 3'h2}, {4'h4, 3'h1, 3'h1}, {4'h5, 3'h3, 3'h3}, {4'h6, 3'h0, 3'h0},
		{4'h7, 3'h2, 3'h2}, {4'h8, 3'h4, 3'h5}, {4'ha, 3'h5, 3'h4}, {4'hc, 3'h5, 3'h5}, {4'he, 3'h4, 3'h4}};

	always #5 pclk = ~pclk;

	// released pins rest at the pull-up level; the remote drives the receive pin
	always_comb
	begin
		for (int i = 0; i < 6; i++)
			p2_in[i] = p2_oe[i] ? p2_out[i] : ((i == rx_idx) ? r_line : 1'b1);
	end

	dspc_ctrl dspc_ctrl_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.p2_pin_in(p2_in), .p2_pin_out(p2_out), .p2_pin_oe(p2_oe), .p1_pin_in(p1_in),
		.p1_pin_out(), .p1_pin_oe(p1_oe));
	dspc_remote dspc_remote_i (.pclk(pclk), .line_in(p2_in[tx_idx]), .bit_cycles(bitc), .nine(nine),
		.send(send), .send_word(send_word), .line_out(r_line), .got(got), .got_word(got_word));

	task automatic cmp_val(input string what, input logic [32:0] exp, input logic [32:0] act);
		num_checks++;
		if (act !== exp)
		begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, act);
		end
	endtask

	task automatic cmp_ser(input logic [8:0] exp, input logic [8:0] act);
		num_checks++;
		if (act !== exp)
		begin
			mismatches++;
			$display("[ERR] serial word expected %h seen %h", exp, act);
		end
	endtask

	task automatic conclude;
		if (mismatches == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	function automatic logic [11:0] ad(input logic [7:0] idx);
		return {2'b00, idx, 2'b00};
	endfunction

	// one apb transfer; waits for pready with no assumed latency
	task automatic apb(input logic [11:0] a, input logic wr, input logic [7:0] wd);
		@(posedge pclk);
		paddr <= a;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		pwdata <= {24'h00_0000, wd};
		@(posedge pclk);
		penable <= 1'b1;
		// only the watchdog ends a wait for the answer
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] v);
		apb(ad(idx), 1'b1, v);
	endtask

	task automatic rd(input logic [11:0] a, input logic [32:0] exp);
		reg_notes.push_back(exp);
		apb(a, 1'b0, 8'h00);
	endtask

	task automatic wait_got;
		int n;
		n = 0;
		while (got !== 1'b1 && n < 20000)
		begin
			@(posedge pclk);
			n++;
		end
		cmp_val("frame seen", 33'h0_0000_0001, {32'h0000_0000, got});
	endtask

	task automatic remote_send(input logic [8:0] w);
		send_word <= w;
		send <= 1'b1;
		@(posedge pclk);
		send <= 1'b0;
		repeat (12 * 96) @(posedge pclk);
	endtask

	// read answers, taken at the edge where pready is sampled
	always @(posedge pclk)
		if (psel && penable && pready === 1'b1 && !pwrite)
			cmp_val("read", reg_notes.size() > 0 ? reg_notes.pop_front() : 33'h1_ffff_ffff, {pslverr, prdata});

	// frames caught by the remote device
	always @(posedge pclk)
		if (got === 1'b1)
			cmp_ser(ser_notes.size() > 0 ? ser_notes.pop_front() : ~got_word, got_word);

	// main sequence
	initial
	begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rd(ad(`DSPC_IDX_P2CTL), 33'h0_0000_0000);
		rd(ad(`DSPC_IDX_PINSEL), 33'h0_0000_0011);
		rd(12'h141, 33'h1_0000_0000);
		// port1 resets to shift mode: clock pin driven, data pin released
		cmp_val("port1 oe", 33'h0_0000_0008, {29'h0000_0000, p1_oe});
		wr(`DSPC_IDX_P2BAUD, 8'h01);
		for (int k = 0; k < 12; k++)
		begin
			rx_idx <= routes[k][5:3];
			tx_idx <= routes[k][2:0];
			wr(`DSPC_IDX_PINSEL, {routes[k][9:6], 4'h1});
			d = 8'($random(seed));
			ser_notes.push_back({1'b0, d});
			wr(`DSPC_IDX_P2BUF, d);
			wait_got;
			rd(ad(`DSPC_IDX_P2CTL), 33'h0_0000_0002);
			wr(`DSPC_IDX_P2CTL, 8'h00);
			repeat (32) @(posedge pclk);
		end
		// port1 shift frame: eight bits at two clocks each
		wr(`DSPC_IDX_P1BUF, d);
		repeat (20) @(posedge pclk);
		rd(ad(`DSPC_IDX_P1CTL), 33'h0_0000_0002);
		rd(ad(`DSPC_IDX_P1BUF), 33'h0_0000_0000);
		rd(ad(`DSPC_IDX_IRQST), 33'h0_0000_0005);
		cmp_val("irq masked", 33'h0_0000_0000, {32'h0000_0000, irq});
		// nine-bit frame at a slower divisor
		wr(`DSPC_IDX_P2BAUD, 8'h03);
		wr(`DSPC_IDX_PINSEL, 8'h11);
		rx_idx <= 3'h2;
		tx_idx <= 3'h3;
		bitc <= 16'h0060;
		nine <= 1'b1;
		d = 8'($random(seed));
		ser_notes.push_back({1'b1, d});
		wr(`DSPC_IDX_P2CTL, 8'h88);
		wr(`DSPC_IDX_P2BUF, d);
		wait_got;
		rd(ad(`DSPC_IDX_P2CTL), 33'h0_0000_008a);
		repeat (96) @(posedge pclk);
		// reception blocked, then allowed with the interrupt unmasked
		wr(`DSPC_IDX_P2CTL, 8'h80);
		remote_send({1'b1, d});
		rd(ad(`DSPC_IDX_P2CTL), 33'h0_0000_0080);
		wr(`DSPC_IDX_IRQMSK, 8'h08);
		wr(`DSPC_IDX_P2CTL, 8'h90);
		d = 8'($random(seed));
		remote_send({1'b1, d});
		rd(ad(`DSPC_IDX_P2CTL), 33'h0_0000_0095);
		rd(ad(`DSPC_IDX_P2BUF), {25'h000_0000, d});
		cmp_val("irq raised", 33'h0_0000_0001, {32'h0000_0000, irq});
		wr(`DSPC_IDX_IRQST, 8'h08);
		repeat (3) @(posedge pclk);
		cmp_val("irq cleared", 33'h0_0000_0000, {32'h0000_0000, irq});
		conclude;
	end

	// hang guard, far beyond the expected run
	initial
	begin
		repeat (60000) @(posedge pclk);
		mismatches++;
		conclude;
	end
endmodule
